// >>> rtl/rs_pkg.sv
// Shared constants, field layouts and types of the resource instance select block
package rs_pkg;

	localparam int RIS_W   = 4;
	localparam int PARAM_W = 16;
	localparam int PART_W  = 16;
	localparam int ADDR_W  = 12;

	// Architecture version reported to software
	localparam logic [3:0] ARCH_MAJOR = 4'h1;
	localparam logic [3:0] ARCH_MINOR = 4'h1;
	localparam logic [RIS_W-1:0] HIGHEST_INSTANCE = 4'h3;
	localparam logic INSTANCE_SELECT_PRESENT = 1'b1;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_ARCH_ID   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_FEAT_ID   = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_PRI_ID    = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_CCAP_ID   = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_CPOR_ID   = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_BW_ID     = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_MON_ID    = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_STMON_ID  = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_CUSTOM_ID = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_ERR_STAT  = 12'h0f8;
	localparam logic [ADDR_W-1:0] OFS_CFG_SEL   = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_CFG_PARAM = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_MON_SEL   = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_MON_VALUE = 12'h204;

	// Field positions
	localparam int ARCH_MINOR_LSB = 0;
	localparam int ARCH_MAJOR_LSB = 4;
	localparam int FID_PRI_BIT    = 0;
	localparam int FID_BW_BIT     = 1;
	localparam int FID_POR_BIT    = 2;
	localparam int FID_CAP_BIT    = 3;
	localparam int FID_MON_BIT    = 4;
	localparam int FID_CUST_BIT   = 5;
	localparam int FID_NOMON_BIT  = 6;
	localparam int FID_NOPART_BIT = 7;
	localparam int FID_INSEL_BIT  = 8;
	localparam int FID_HIGH_LSB   = 24;
	localparam int PRI_DS_BIT     = 0;
	localparam int PRI_DS_LOW_BIT = 1;
	localparam int PRI_DS_W_LSB   = 4;
	localparam int PRI_IN_BIT     = 16;
	localparam int PRI_IN_LOW_BIT = 17;
	localparam int PRI_IN_W_LSB   = 20;
	localparam int MON_BW_BIT     = 16;
	localparam int MON_ST_BIT     = 17;
	localparam int STM_RO_BIT     = 29;
	localparam int STM_CAPT_BIT   = 31;
	localparam int SEL_PART_LSB   = 0;
	localparam int SEL_RIS_LSB    = 24;
	localparam int SEL_SPACE_BIT  = 31;
	localparam int ESR_RIS_LSB    = 8;
	localparam int ESR_CODE_LSB   = 24;
	localparam int ESR_OVF_BIT    = 31;

	// Error codes
	localparam logic [3:0] ERR_NONE          = 4'h0;
	localparam logic [3:0] ERR_PARTITION_IDENTIFIER_RANGE  = 4'h1;
	localparam logic [3:0] ERR_CFG_RIS_UNDEF = 4'h8;
	localparam logic [3:0] ERR_CFG_NO_CTRL   = 4'h9;
	localparam logic [3:0] ERR_MON_RIS_UNDEF = 4'ha;
	localparam logic [3:0] ERR_MON_NO_TYPE   = 4'hb;

	typedef struct packed {
		logic        defined;
		logic        pri_present;
		logic        bw_present;
		logic        por_present;
		logic        cap_present;
		logic        mon_present;
		logic        custom_present;
		logic        no_custom_monitors;
		logic        no_custom_partitioning;
		logic        bw_mon_flag;
		logic        stor_mon_flag;
		logic        ds_present;
		logic        ds_zero_low;
		logic [5:0]  ds_width;
		logic        in_present;
		logic        in_zero_low;
		logic [5:0]  in_width;
		logic [5:0]  cap_max_width;
		logic [15:0] portion_bitmap_width;
		logic        stor_readonly;
		logic        stor_capture;
		logic [15:0] monitor_count;
		logic [31:0] bw_id;
		logic [31:0] custom_id;
	} rs_cap_s;

	typedef struct packed {
		logic               valid;
		logic               space;
		logic [PART_W-1:0]  partition_identifier;
		logic [RIS_W-1:0]   inst;
	} rs_req_s;

	typedef struct packed {
		logic               valid;
		logic [PARAM_W-1:0] param;
	} rs_rsp_s;

	localparam rs_cap_s CAP_NONE = '0;
	// Instance 0: cache portion and capacity with storage monitors
	localparam rs_cap_s CAP_INST0 = '{defined: 1'b1, por_present: 1'b1, cap_present: 1'b1,
		mon_present: 1'b1, no_custom_monitors: 1'b1, no_custom_partitioning: 1'b1,
		stor_mon_flag: 1'b1, cap_max_width: 6'h08, portion_bitmap_width: 16'h0010,
		stor_capture: 1'b1, monitor_count: 16'h0004, default: '0};
	// Instance 1: bandwidth partitioning with bandwidth monitor
	localparam rs_cap_s CAP_INST1 = '{defined: 1'b1, bw_present: 1'b1, mon_present: 1'b1,
		no_custom_monitors: 1'b1, no_custom_partitioning: 1'b1, bw_mon_flag: 1'b1,
		bw_id: 32'h0000_0008, default: '0};
	// Instance 3: priority partitioning and a custom ID register
	localparam rs_cap_s CAP_INST3 = '{defined: 1'b1, pri_present: 1'b1, custom_present: 1'b1,
		ds_present: 1'b1, ds_zero_low: 1'b1, ds_width: 6'h04, in_present: 1'b1,
		in_width: 6'h03, custom_id: 32'h0000_0001, default: '0};

endpackage

// >>> rtl/rs_cap_rom.sv
// Capability lookup for one resource instance selector value
`timescale 1ns/1ps
module rs_cap_rom (
	input  wire logic [rs_pkg::RIS_W-1:0] ris_i,
	output rs_pkg::rs_cap_s                cap_o
);
	import rs_pkg::*;

	always_comb begin
		unique case (ris_i)
			4'h0: cap_o = CAP_INST0;
			4'h1: cap_o = CAP_INST1;
			4'h3: cap_o = CAP_INST3;
			default: cap_o = CAP_NONE;
		endcase
	end
endmodule

// >>> rtl/rs_instance_select.sv
// Resource instance selection, ID registers and per-instance controls on AHB-Lite
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module rs_instance_select #(
	parameter int NUM_INST = 4,
	parameter int NUM_PART = 8
) (
	input  wire logic                CORE_CLK_I,
	input  wire logic                RST_I,
	input  wire logic                HSEL_I,
	input  wire logic [31:0]         HADDR_I,
	input  wire logic [1:0]          HTRANS_I,
	input  wire logic                HWRITE_I,
	input  wire logic [2:0]          HSIZE_I,
	input  wire logic [31:0]         HWDATA_I,
	input  wire logic                HREADY_I,
	output logic      [31:0]         HRDATA_O,
	output logic                     HREADYOUT_O,
	output logic                     HRESP_O,
	input  rs_pkg::rs_req_s          REQ_I,
	output rs_pkg::rs_rsp_s          RSP_O
);
	import rs_pkg::*;

	// Index widths into the parameter store and the counters
	localparam int IDX_W  = (NUM_INST > 1) ? $clog2(NUM_INST) : 1;
	localparam int PIDX_W = (NUM_PART > 1) ? $clog2(NUM_PART) : 1;
	localparam logic [PART_W-1:0] PART_LIMIT = PART_W'(NUM_PART);

	// The partition limit must fit the partition field, so 2**PART_W is refused
	if (NUM_INST != int'(HIGHEST_INSTANCE) + 1 || NUM_INST > 2 ** RIS_W ||
			NUM_PART < 2 || NUM_PART >= 2 ** PART_W) begin : g_bad_param
		$error("rs_instance_select: unsupported NUM_INST or NUM_PART");
	end

	// Whole state: bus phase, selectors, error status, parameters, counters, request response
	typedef struct packed {
		logic                                             ph_valid;
		logic                                             ph_write;
		logic [ADDR_W-1:0]                                ph_addr;
		logic                                             rd_wait;
		logic [31:0]                                      rdata;
		logic [PART_W-1:0]                                sel_part;
		logic [RIS_W-1:0]                                 sel_ris;
		logic                                             sel_space;
		logic [PART_W-1:0]                                mon_num;
		logic [RIS_W-1:0]                                 mon_ris;
		logic [3:0]                                       esr_code;
		logic [RIS_W-1:0]                                 esr_ris;
		logic                                             esr_ovf;
		logic [NUM_INST-1:0][1:0][NUM_PART-1:0][PARAM_W-1:0] params;
		logic [NUM_INST-1:0][31:0]                        mon_cnt;
		rs_rsp_s                                          rsp;
	} rs_state_s;

	rs_state_s         state_reg;
	rs_state_s         state_next;
	rs_cap_s           sel_cap;
	rs_cap_s           mon_cap;
	rs_cap_s           req_cap;
	logic [3:0]        cfg_code;
	logic [RIS_W-1:0]  cfg_err_ris;
	logic [3:0]        mon_code;
	logic [RIS_W-1:0]  mon_err_ris;
	logic [31:0]       rd_mux;
	logic              err_ev;
	logic [3:0]        err_code;
	logic [RIS_W-1:0]  err_ris;
	logic [IDX_W-1:0]  sel_idx;
	logic [IDX_W-1:0]  mon_idx;
	logic [IDX_W-1:0]  req_idx;
	logic [PIDX_W-1:0] part_idx;

	// ID registers and config accesses follow the config selector
	rs_cap_rom u_sel_cap (
		.ris_i (state_reg.sel_ris),
		.cap_o (sel_cap)
	);

	// Monitor registers follow the monitor selector
	rs_cap_rom u_mon_cap (
		.ris_i (state_reg.mon_ris),
		.cap_o (mon_cap)
	);

	// Requests look up their own instance, not the config selector
	rs_cap_rom u_req_cap (
		.ris_i (REQ_I.inst),
		.cap_o (req_cap)
	);

	// Indices beyond the defined range are gated by the capability checks
	assign sel_idx  = state_reg.sel_ris[IDX_W-1:0];
	assign mon_idx  = state_reg.mon_ris[IDX_W-1:0];
	assign req_idx  = REQ_I.inst[IDX_W-1:0];
	assign part_idx = state_reg.sel_part[PIDX_W-1:0];

	// Checks for a configuration parameter access
	always_comb begin
		// Errors of config accesses log the config selector, except a partition range error
		cfg_err_ris = state_reg.sel_ris;
		if (!sel_cap.defined) begin
			cfg_code = ERR_CFG_RIS_UNDEF;
		end else if (!(sel_cap.pri_present || sel_cap.bw_present ||
				sel_cap.por_present || sel_cap.cap_present)) begin
			cfg_code = ERR_CFG_NO_CTRL;
		end else if (state_reg.sel_part >= PART_LIMIT) begin
			// An out-of-range partition carries no selector, so instance 0 is logged
			cfg_code = ERR_PARTITION_IDENTIFIER_RANGE;
			cfg_err_ris = '0;
		end else begin
			cfg_code = ERR_NONE;
		end
	end

	// Checks for a monitor value access
	always_comb begin
		// Monitor accesses follow the monitor selector alone
		mon_err_ris = state_reg.mon_ris;
		if (!mon_cap.defined) begin
			mon_code = ERR_MON_RIS_UNDEF;
		end else if (!mon_cap.mon_present) begin
			mon_code = ERR_MON_NO_TYPE;
		end else begin
			mon_code = ERR_NONE;
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = '0;
		// ID reads never log errors, even for an undefined instance
		unique case (state_reg.ph_addr)
			OFS_ARCH_ID: begin
				rd_mux[ARCH_MINOR_LSB +: 4] = ARCH_MINOR;
				rd_mux[ARCH_MAJOR_LSB +: 4] = ARCH_MAJOR;
			end
			OFS_FEAT_ID: begin
				rd_mux[FID_PRI_BIT]    = sel_cap.pri_present;
				rd_mux[FID_BW_BIT]     = sel_cap.bw_present;
				rd_mux[FID_POR_BIT]    = sel_cap.por_present;
				rd_mux[FID_CAP_BIT]    = sel_cap.cap_present;
				rd_mux[FID_MON_BIT]    = sel_cap.mon_present;
				rd_mux[FID_CUST_BIT]   = sel_cap.custom_present;
				rd_mux[FID_NOMON_BIT]  = sel_cap.no_custom_monitors;
				rd_mux[FID_NOPART_BIT] = sel_cap.no_custom_partitioning;
				rd_mux[FID_INSEL_BIT]  = INSTANCE_SELECT_PRESENT;
				rd_mux[FID_HIGH_LSB +: RIS_W] = HIGHEST_INSTANCE;
			end
			OFS_PRI_ID: begin
				rd_mux[PRI_DS_BIT]     = sel_cap.ds_present;
				rd_mux[PRI_DS_LOW_BIT] = sel_cap.ds_zero_low;
				rd_mux[PRI_DS_W_LSB +: 6] = sel_cap.ds_width;
				rd_mux[PRI_IN_BIT]     = sel_cap.in_present;
				rd_mux[PRI_IN_LOW_BIT] = sel_cap.in_zero_low;
				rd_mux[PRI_IN_W_LSB +: 6] = sel_cap.in_width;
			end
			OFS_CCAP_ID: rd_mux[5:0] = sel_cap.cap_max_width;
			OFS_CPOR_ID: rd_mux[15:0] = sel_cap.portion_bitmap_width;
			OFS_BW_ID: rd_mux = sel_cap.bw_id;
			OFS_MON_ID: begin
				rd_mux[MON_BW_BIT] = sel_cap.bw_mon_flag;
				rd_mux[MON_ST_BIT] = sel_cap.stor_mon_flag;
			end
			OFS_STMON_ID: begin
				rd_mux[15:0]         = sel_cap.monitor_count;
				rd_mux[STM_RO_BIT]   = sel_cap.stor_readonly;
				rd_mux[STM_CAPT_BIT] = sel_cap.stor_capture;
			end
			OFS_CUSTOM_ID: rd_mux = sel_cap.custom_id;
			OFS_ERR_STAT: begin
				rd_mux[ESR_RIS_LSB +: RIS_W] = state_reg.esr_ris;
				rd_mux[ESR_CODE_LSB +: 4]    = state_reg.esr_code;
				rd_mux[ESR_OVF_BIT]          = state_reg.esr_ovf;
			end
			OFS_CFG_SEL: begin
				rd_mux[SEL_PART_LSB +: PART_W] = state_reg.sel_part;
				rd_mux[SEL_RIS_LSB +: RIS_W]   = state_reg.sel_ris;
				rd_mux[SEL_SPACE_BIT]          = state_reg.sel_space;
			end
			OFS_CFG_PARAM: begin
				if (cfg_code == ERR_NONE) begin
					// Refused accesses read as zero
					rd_mux[PARAM_W-1:0] =
						state_reg.params[sel_idx][state_reg.sel_space][part_idx];
				end
			end
			OFS_MON_SEL: begin
				rd_mux[SEL_PART_LSB +: PART_W] = state_reg.mon_num;
				rd_mux[SEL_RIS_LSB +: RIS_W]   = state_reg.mon_ris;
			end
			OFS_MON_VALUE: begin
				if (mon_code == ERR_NONE) begin
					rd_mux = state_reg.mon_cnt[mon_idx];
				end
			end
			default: rd_mux = '0;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		err_ev = 1'b0;
		err_code = ERR_NONE;
		err_ris = '0;

		// Request side parameter lookup, zero for unknown instance or partition
		// The answer is registered, one cycle after the request
		state_next.rsp.valid = REQ_I.valid;
		state_next.rsp.param = '0;
		if (REQ_I.valid && req_cap.defined && REQ_I.partition_identifier < PART_LIMIT) begin
			state_next.rsp.param =
				state_reg.params[req_idx][REQ_I.space][REQ_I.partition_identifier[PIDX_W-1:0]];
		end

		// Per-instance usage monitor counts requests that reach it
		// Undefined instances and instances without monitors count nothing
		if (REQ_I.valid && req_cap.defined && req_cap.mon_present) begin
			state_next.mon_cnt[req_idx] = state_reg.mon_cnt[req_idx] + 32'h1;
		end

		// Data phase of a write
		if (state_reg.ph_valid && state_reg.ph_write) begin
			unique case (state_reg.ph_addr)
				OFS_CFG_SEL: begin
					state_next.sel_part  = HWDATA_I[SEL_PART_LSB +: PART_W];
					state_next.sel_ris   = HWDATA_I[SEL_RIS_LSB +: RIS_W];
					state_next.sel_space = HWDATA_I[SEL_SPACE_BIT];
				end
				OFS_MON_SEL: begin
					state_next.mon_num = HWDATA_I[SEL_PART_LSB +: PART_W];
					state_next.mon_ris = HWDATA_I[SEL_RIS_LSB +: RIS_W];
				end
				OFS_ERR_STAT: begin
					// Any write clears the error status
					state_next.esr_code = ERR_NONE;
					state_next.esr_ris  = '0;
					state_next.esr_ovf  = 1'b0;
				end
				OFS_CFG_PARAM: begin
					if (cfg_code == ERR_NONE) begin
						state_next.params[sel_idx][state_reg.sel_space][part_idx] =
							HWDATA_I[PARAM_W-1:0];
					end else begin
						err_ev = 1'b1;
						err_code = cfg_code;
						err_ris = cfg_err_ris;
					end
				end
				OFS_MON_VALUE: begin
					if (mon_code == ERR_NONE) begin
						// A software load wins over a request increment
						state_next.mon_cnt[mon_idx] = HWDATA_I;
					end else begin
						err_ev = 1'b1;
						err_code = mon_code;
						err_ris = mon_err_ris;
					end
				end
				default: begin
					// Other offsets are read-only or unmapped
				end
			endcase
		end

		// Read: one wait cycle to register the data
		// A refused read logs its error in the first data cycle
		if (state_reg.ph_valid && !state_reg.ph_write && !state_reg.rd_wait) begin
			state_next.rd_wait = 1'b1;
			state_next.rdata = rd_mux;
			if (state_reg.ph_addr == OFS_CFG_PARAM && cfg_code != ERR_NONE) begin
				err_ev = 1'b1;
				err_code = cfg_code;
				err_ris = cfg_err_ris;
			end
			if (state_reg.ph_addr == OFS_MON_VALUE && mon_code != ERR_NONE) begin
				err_ev = 1'b1;
				err_code = mon_code;
				err_ris = mon_err_ris;
			end
		end else if (state_reg.rd_wait) begin
			state_next.rd_wait = 1'b0;
		end

		// Address phase capture
		// Only low address bits decode, so the map repeats every 4 KiB
		if (HREADY_I) begin
			state_next.ph_valid = HSEL_I && HTRANS_I[1];
			state_next.ph_write = HWRITE_I;
			state_next.ph_addr  = {HADDR_I[ADDR_W-1:2], 2'b00};
		end

		// A new error wins over a clear in the same cycle
		// Overflow marks an error that lands on an uncleared status
		if (err_ev) begin
			state_next.esr_ovf  = state_reg.esr_code != ERR_NONE;
			state_next.esr_code = err_code;
			state_next.esr_ris  = err_ris;
		end
	end

	// Reset clears both selectors, so unaware software reaches instance 0
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Wait state only in the first data cycle of a read
	assign HREADYOUT_O = !(state_reg.ph_valid && !state_reg.ph_write && !state_reg.rd_wait);
	assign HRDATA_O    = state_reg.rdata;
	// Every transfer completes with an OKAY response
	assign HRESP_O     = 1'b0;
	assign RSP_O       = state_reg.rsp;

endmodule

// >>> testbench/rs_requester.sv
// Behavioural memory requester that drives the request port
`timescale 1ns/1ps
module rs_requester (
	input  wire logic       clk_i,
	output rs_pkg::rs_req_s req_o,
	input  rs_pkg::rs_rsp_s rsp_i
);
	import rs_pkg::*;
	initial req_o = '0;
	// One request; the answer is sampled once it has settled
	task automatic issue(input logic [RIS_W-1:0] inst, input logic space,
		input logic [PART_W-1:0] partition_identifier, output rs_rsp_s rsp);
		req_o <= '{valid: 1'b1, space: space, partition_identifier: partition_identifier, inst: inst};
		@(posedge clk_i);
		// Idle fields flip so a stale request cannot pass for a new one
		req_o <= '{valid: 1'b0, space: ~space, partition_identifier: ~partition_identifier, inst: ~inst};
		@(negedge clk_i);
		rsp = rsp_i;
		@(posedge clk_i);
	endtask
endmodule

// >>> testbench/rs_checker_assertions.sv
// Port-level checks on the resource instance select block
`timescale 1ns/1ps
module rs_checker #(
	parameter int NUM_PART = 8
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	input  wire logic [31:0] HRDATA_O,
	input  wire logic        HREADYOUT_O,
	input  wire logic        HRESP_O,
	input  rs_pkg::rs_req_s  REQ_I,
	input  rs_pkg::rs_rsp_s  RSP_O
);
	import rs_pkg::*;
	logic take;
	logic rd_take;
	assign take    = HREADY_I & HSEL_I & HTRANS_I[1];
	assign rd_take = take & ~HWRITE_I;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	resp_okay_a: assert property (HRESP_O == 1'b0)
		else $error("bus response not OKAY");
	read_wait_a: assert property (rd_take |=> !HREADYOUT_O ##1 HREADYOUT_O)
		else $error("read data phase not one wait state");
	write_nowait_a: assert property (take && HWRITE_I |=> HREADYOUT_O)
		else $error("write data phase stalled");
	ready_low_a: assert property (!HREADYOUT_O |-> $past(rd_take))
		else $error("wait state without a read");
	rdata_hold_a: assert property (!$past(rd_take, 2) |-> $stable(HRDATA_O))
		else $error("read data changed without a read");
	rsp_valid_a: assert property (RSP_O.valid == $past(REQ_I.valid))
		else $error("response valid not one cycle after request");
	rsp_undef_a: assert property (REQ_I.valid && (REQ_I.inst == 4'h2 ||
		REQ_I.inst > HIGHEST_INSTANCE) |=> RSP_O.param == 16'h0000)
		else $error("undefined instance gave a parameter");
	rsp_range_a: assert property (REQ_I.valid && REQ_I.partition_identifier >= NUM_PART
		|=> RSP_O.param == 16'h0000)
		else $error("partition out of range gave a parameter");
endmodule
bind rs_instance_select rs_checker #(.NUM_PART(NUM_PART)) chk_u (
	.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
	.HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
	.HRESP_O(HRESP_O), .REQ_I(REQ_I), .RSP_O(RSP_O)
);

// >>> testbench/testbench.sv
// Self-checking bench for the resource instance select block
`timescale 1ns/1ps
module testbench;
	import rs_pkg::*;
	typedef struct packed {
		logic [3:0]  resource_instance_selector;
		logic [11:0] addr;
		logic [31:0] mask;
		logic [31:0] exp;
	} rs_row_s;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic        hrdy;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	rs_req_s     req;
	rs_rsp_s     rsp;
	int          failures = 0;
	int          compares = 0;
	rs_row_s     rows [21];
	always #20 clk = ~clk;
	rs_instance_select #(.NUM_INST(4), .NUM_PART(8)) dut_u (
		.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.REQ_I(req), .RSP_O(rsp)
	);
	rs_requester req_u (.clk_i(clk), .req_o(req), .rsp_i(rsp));
	// Single transfer; hready and read data are sampled at the rising edge
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {20'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (!hrdy);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (!hrdy);
		rd = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		ahb(1'b0, a, '0);
		chk(n, e, rd);
	endtask
	function automatic logic [31:0] sel(input logic [3:0] r, input logic s, input logic [15:0] p);
		return {s, 3'h0, r, 8'h0, p};
	endfunction
	task automatic prm(input logic [3:0] r, input logic s, input logic [15:0] p,
		input logic [31:0] d);
		wr(OFS_CFG_SEL, sel(r, s, p));
		wr(OFS_CFG_PARAM, d);
	endtask
	task automatic rq(input logic [3:0] i, input logic s, input logic [15:0] p,
		input logic [15:0] e);
		rs_rsp_s r;
		req_u.issue(i, s, p, r);
		chk("response", {15'h0, 1'b1, e}, {15'h0, r});
	endtask
	task automatic do_reset(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		@(negedge clk);
		chk("reset ready", 32'h1, {31'h0, hrdy});
		chk("reset rdata", 32'h0, hrdata);
		chk("reset response", 32'h0, {15'h0, rsp});
		@(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rows = '{
			'{4'h0, OFS_FEAT_ID, 32'hffffffff, 32'h030001dc},
			'{4'h1, OFS_FEAT_ID, 32'hffffffff, 32'h030001d2},
			'{4'h2, OFS_FEAT_ID, 32'h000000ff, 32'h00000000},
			'{4'h3, OFS_FEAT_ID, 32'hffffffff, 32'h03000121},
			'{4'h3, OFS_PRI_ID, 32'hffffffff, 32'h00310043},
			'{4'h0, OFS_PRI_ID, 32'hffffffff, 32'h00000000},
			'{4'h0, OFS_CCAP_ID, 32'hffffffff, 32'h00000008},
			'{4'h1, OFS_CCAP_ID, 32'hffffffff, 32'h00000000},
			'{4'h0, OFS_CPOR_ID, 32'hffffffff, 32'h00000010},
			'{4'h0, OFS_BW_ID, 32'hffffffff, 32'h00000000},
			'{4'h1, OFS_BW_ID, 32'hffffffff, 32'h00000008},
			'{4'h0, OFS_MON_ID, 32'hffffffff, 32'h00020000},
			'{4'h1, OFS_MON_ID, 32'hffffffff, 32'h00010000},
			'{4'h2, OFS_MON_ID, 32'hffffffff, 32'h00000000},
			'{4'h0, OFS_STMON_ID, 32'hffffffff, 32'h80000004},
			'{4'h1, OFS_STMON_ID, 32'hffffffff, 32'h00000000},
			'{4'h3, OFS_CUSTOM_ID, 32'hffffffff, 32'h00000001},
			'{4'h0, OFS_CUSTOM_ID, 32'hffffffff, 32'h00000000},
			'{4'h3, OFS_ARCH_ID, 32'hffffffff, 32'h00000011},
			'{4'h2, OFS_ERR_STAT, 32'hffffffff, 32'h00000000},
			'{4'h0, 12'h300, 32'hffffffff, 32'h00000000}};
		do_reset(15);
		foreach (rows[i]) begin
			wr(OFS_CFG_SEL, sel(rows[i].resource_instance_selector, 1'b0, 16'h0));
			ahb(1'b0, rows[i].addr, '0);
			chk("id register", rows[i].exp, rd & rows[i].mask);
		end
		prm(4'h0, 1'b1, 16'h5, 32'h1234);
		prm(4'h0, 1'b0, 16'h5, 32'h5678);
		prm(4'h1, 1'b1, 16'h5, 32'h9abc);
		rdc("param", OFS_CFG_PARAM, 32'h9abc);
		rdc("select", OFS_CFG_SEL, sel(4'h1, 1'b1, 16'h5));
		wr(OFS_CFG_SEL, sel(4'h0, 1'b1, 16'h5));
		rdc("param", OFS_CFG_PARAM, 32'h1234);
		rq(4'h0, 1'b1, 16'h5, 16'h1234);
		rq(4'h0, 1'b0, 16'h5, 16'h5678);
		rq(4'h1, 1'b1, 16'h5, 16'h9abc);
		rq(4'h1, 1'b0, 16'h5, 16'h0000);
		rq(4'h2, 1'b1, 16'h5, 16'h0000);
		rq(4'h0, 1'b1, 16'h9, 16'h0000);
		wr(OFS_ERR_STAT, 32'h0);
		wr(OFS_CFG_SEL, sel(4'h2, 1'b0, 16'h0));
		ahb(1'b0, OFS_CFG_PARAM, '0);
		rdc("error status", OFS_ERR_STAT, 32'h08000200);
		wr(OFS_ERR_STAT, 32'h0);
		rdc("error status", OFS_ERR_STAT, 32'h0);
		wr(OFS_CFG_SEL, sel(4'h1, 1'b0, 16'h9));
		ahb(1'b0, OFS_CFG_PARAM, '0);
		rdc("error status", OFS_ERR_STAT, 32'h01000000);
		wr(OFS_CFG_SEL, sel(4'h3, 1'b0, 16'h0));
		wr(OFS_MON_SEL, 32'h0);
		wr(OFS_MON_VALUE, 32'h0);
		wr(OFS_MON_SEL, 32'h01000000);
		wr(OFS_MON_VALUE, 32'h0);
		rq(4'h0, 1'b0, 16'h1, 16'h0000);
		rq(4'h0, 1'b0, 16'h1, 16'h0000);
		rq(4'h1, 1'b0, 16'h1, 16'h0000);
		rq(4'h2, 1'b0, 16'h1, 16'h0000);
		rdc("monitor value", OFS_MON_VALUE, 32'h1);
		wr(OFS_MON_SEL, 32'h0);
		rdc("monitor value", OFS_MON_VALUE, 32'h2);
		wr(OFS_ERR_STAT, 32'h0);
		wr(OFS_MON_SEL, 32'h03000000);
		rdc("monitor value", OFS_MON_VALUE, 32'h0);
		rdc("error status", OFS_ERR_STAT, 32'h0b000300);
		do_reset(2);
		rdc("select", OFS_CFG_SEL, 32'h0);
		rdc("feature id", OFS_FEAT_ID, 32'h030001dc);
		rq(4'h0, 1'b1, 16'h5, 16'h0000);
		results();
	end
	initial begin
		#2000000;
		failures++;
		results();
	end
endmodule
